// *** core/real_bit_compare_shift_unit.sv ***
`timescale 1ns/1ns
// Overview of operation
// - real round to int, halves away zero
// - real truncate to int, drop fraction
// - int to single real, rounded
// - single real widened into register pair
// - single add, sub, mul, div, negate
// - double ops mirror single on pairs
// - clear pair bit indexed modulo 64
// - set pair bit indexed modulo 64
// - test pair bit into bit 0
// - signed relation test writes one or zero
// - unsigned compare writes -1, 0, +1
// - signed pair compare writes -1, 0, +1
// - single real sign-magnitude compare
// - double real sign-magnitude compare
// - register counts use 5 or 6 bits
// - immediate shift count 0 to 15
// - barrel shifter, fixed latency
// - rotate, logical, arithmetic and pair shifts
// - rotate wraps msb into lsb
// - arithmetic left keeps sign bit
// - immediate field used as constant
module real_bit_compare_shift_unit
    import real_bit_compare_shift_unit_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    input  wire logic        op_valid,
    input  wire op_e         op_code,
    input  wire logic        imm_sel,
    input  wire logic [2:0]  relop,
    input  wire logic [3:0]  imm_val,
    input  wire logic [31:0] dst_hi,
    input  wire logic [31:0] dst_lo,
    input  wire logic [31:0] src_hi,
    input  wire logic [31:0] src_lo,
    output logic             done_ff,
    output logic             pair_wr_ff,
    output logic [31:0]      res_hi_ff,
    output logic [31:0]      res_lo_ff
);

    // split a real into sign, unbiased exponent, mantissa with lead at bit 63
    function automatic fp_s fp_unpack(input logic [63:0] x, input logic dbl);
        fp_s u;
        u = '0;
        if (dbl)
        begin
            u.sgn  = x[63];
            u.zero = (x[62:52] == 11'h000);
            u.exp  = 14'(x[62:52]) - 14'(DBL_BIAS);
            u.man  = {1'b1, x[51:0], 11'h000};
        end
        else
        begin
            u.sgn  = x[31];
            u.zero = (x[30:23] == 8'h00);
            u.exp  = 14'(x[30:23]) - 14'(SGL_BIAS);
            u.man  = {1'b1, x[22:0], 40'h0000000000};
        end
        return u;
    endfunction : fp_unpack

    // normalise, round half away, clamp to infinity or zero
    function automatic logic [63:0] fp_pack(input logic s, input logic signed [13:0] e_in,
                                            input logic [63:0] m_in, input logic dbl);
        logic [63:0]        m;
        logic signed [13:0] e;
        logic signed [13:0] be;
        logic [53:0]        rd;
        logic [24:0]        rs;
        logic [63:0]        r;
        int                 lz;
        m  = m_in;
        e  = e_in;
        lz = 0;
        rd = '0;
        rs = '0;
        be = '0;
        for (int i = 0; i < 64; i++)
            if (m[i])
                lz = 63 - i;
        if (m == 64'h0)
            r = dbl ? {s, 63'h0} : {32'h0, s, 31'h0};
        else
        begin
            m = m << lz;
            e = e - 14'(lz);
            if (dbl)
            begin
                rd = {1'b0, m[63:11]} + 54'(m[10]);
                if (rd[53])
                begin
                    rd = rd >> 1;
                    e  = e + 14'sd1;
                end
                be = e + 14'(DBL_BIAS);
                if (be >= 14'(DBL_EXP_MAX))
                    r = {s, DBL_EXP_ONES, 52'h0};
                else if (be <= 14'sd0)
                    r = {s, 63'h0};
                else
                    r = {s, be[10:0], rd[51:0]};
            end
            else
            begin
                rs = {1'b0, m[63:40]} + 25'(m[39]);
                if (rs[24])
                begin
                    rs = rs >> 1;
                    e  = e + 14'sd1;
                end
                be = e + 14'(SGL_BIAS);
                if (be >= 14'(SGL_EXP_MAX))
                    r = {32'h0, s, SGL_EXP_ONES, 23'h0};
                else if (be <= 14'sd0)
                    r = {32'h0, s, 31'h0};
                else
                    r = {32'h0, s, be[7:0], rs[22:0]};
            end
        end
        return r;
    endfunction : fp_pack

    function automatic logic [63:0] fp_add(input logic [63:0] a, input logic [63:0] b,
                                           input logic dbl, input logic neg_b);
        fp_s                x;
        fp_s                y;
        fp_s                t;
        logic [63:0]        mb;
        logic [64:0]        sum;
        logic signed [13:0] d;
        logic [63:0]        r;
        x = fp_unpack(a, dbl);
        y = fp_unpack(b, dbl);
        y.sgn = y.sgn ^ neg_b;
        if (y.exp > x.exp || (y.exp == x.exp && y.man > x.man))
        begin
            t = x;
            x = y;
            y = t;
        end
        d   = x.exp - y.exp;
        mb  = (y.zero || d > 14'sd63) ? 64'h0 : (y.man >> d);
        sum = '0;
        if (x.zero && y.zero)
            r = fp_pack(x.sgn, x.exp, 64'h0, dbl);
        else if (x.zero)
            r = fp_pack(y.sgn, y.exp, y.man, dbl);
        else
        begin
            sum = (x.sgn == y.sgn) ? {1'b0, x.man} + {1'b0, mb} : {1'b0, x.man} - {1'b0, mb};
            r = fp_pack(x.sgn, x.exp + 14'sd1, sum[64:1], dbl);
        end
        return r;
    endfunction : fp_add

    function automatic logic [63:0] fp_mul(input logic [63:0] a, input logic [63:0] b,
                                           input logic dbl);
        fp_s          x;
        fp_s          y;
        logic [105:0] p;
        logic [63:0]  r;
        x = fp_unpack(a, dbl);
        y = fp_unpack(b, dbl);
        p = x.man[63:11] * y.man[63:11];
        if (x.zero || y.zero)
            r = fp_pack(x.sgn ^ y.sgn, 14'sd0, 64'h0, dbl);
        else
            r = fp_pack(x.sgn ^ y.sgn, x.exp + y.exp + 14'sd1, p[105:42], dbl);
        return r;
    endfunction : fp_mul

    function automatic logic [63:0] fp_div(input logic [63:0] a, input logic [63:0] b,
                                           input logic dbl);
        fp_s          x;
        fp_s          y;
        logic [115:0] q;
        logic         s;
        logic [63:0]  r;
        x = fp_unpack(a, dbl);
        y = fp_unpack(b, dbl);
        s = x.sgn ^ y.sgn;
        q = {x.man[63:11], 63'h0} / {63'h0, y.man[63:11]};
        if (y.zero)
            r = dbl ? {s, DBL_EXP_ONES, 52'h0} : {32'h0, s, SGL_EXP_ONES, 23'h0};
        else if (x.zero)
            r = fp_pack(s, 14'sd0, 64'h0, dbl);
        else
            r = fp_pack(s, x.exp - y.exp + 14'sd1, q[64:1], dbl);
        return r;
    endfunction : fp_div

    // real to integer, saturating when out of range
    function automatic logic [31:0] fp_to_int(input logic [63:0] a, input logic dbl,
                                              input logic rnd);
        fp_s         u;
        logic [64:0] w;
        logic [32:0] mag;
        logic [31:0] r;
        int          sh;
        u   = fp_unpack(a, dbl);
        w   = '0;
        mag = '0;
        sh  = 0;
        if (u.zero || u.exp < -14'sd1)
            r = RES_ZERO;
        else if (u.exp >= 14'sd31)
            r = u.sgn ? INT_NEG_SAT : INT_POS_SAT;
        else
        begin
            sh  = 63 - int'(u.exp);
            w   = {u.man, 1'b0} >> sh;
            mag = {1'b0, w[32:1]} + 33'(rnd & w[0]);
            if (!u.sgn && mag[31])
                r = INT_POS_SAT;
            else
                r = u.sgn ? 32'h0 - mag[31:0] : mag[31:0];
        end
        return r;
    endfunction : fp_to_int

    function automatic logic [63:0] int_to_fp(input logic [31:0] a, input logic dbl);
        logic [31:0] mag;
        mag = a[31] ? 32'h0 - a : a;
        return fp_pack(a[31], 14'sd31, {mag, 32'h0}, dbl);
    endfunction : int_to_fp

    function automatic logic [31:0] order_code(input logic lt, input logic eq);
        return eq ? RES_ZERO : (lt ? RES_MINUS_ONE : RES_PLUS_ONE);
    endfunction : order_code

    // sign-magnitude ordering, plus and minus zero equal
    function automatic logic [31:0] sm_compare(input logic [63:0] a, input logic [63:0] b,
                                               input logic dbl);
        logic        sa;
        logic        sb;
        logic [62:0] ma;
        logic [62:0] mb;
        logic        lt;
        logic        eq;
        sa = dbl ? a[63] : a[31];
        sb = dbl ? b[63] : b[31];
        ma = dbl ? a[62:0] : {32'h0, a[30:0]};
        mb = dbl ? b[62:0] : {32'h0, b[30:0]};
        eq = (ma == mb) && (sa == sb || ma == 63'h0);
        lt = (sa != sb) ? sa : (sa ? ma > mb : ma < mb);
        return order_code(lt, eq);
    endfunction : sm_compare

    // widen and narrow repack through the other format
    function automatic logic [63:0] fp_convert(input logic [63:0] a, input logic to_dbl);
        fp_s u;
        u = fp_unpack(a, !to_dbl);
        return fp_pack(u.sgn, u.exp, u.zero ? 64'h0 : u.man, to_dbl);
    endfunction : fp_convert

    logic [63:0] dst_pair;
    logic [63:0] src_pair;
    logic [31:0] opnd_b;
    logic [4:0]  cnt_sgl;
    logic [5:0]  cnt_pair;
    logic [5:0]  bit_pos;
    logic [63:0] rot_wide;
    logic [63:0] fp_res;
    logic        rel_true;
    logic [31:0] nxt_res_hi;
    logic [31:0] nxt_res_lo;
    logic        nxt_pair_wr;
    logic        nxt_done;

    assign dst_pair = {dst_hi, dst_lo};
    assign src_pair = {src_hi, src_lo};
    assign opnd_b   = imm_sel ? {28'h0, imm_val} : src_hi;
    assign cnt_sgl  = imm_sel ? {1'b0, imm_val} : src_hi[SGL_CNT_W-1:0];
    assign cnt_pair = imm_sel ? {2'b0, imm_val} : src_hi[PAIR_CNT_W-1:0];
    assign bit_pos  = PAIR_TOP_BIT - src_hi[5:0];
    assign rot_wide = {dst_hi, dst_hi} << cnt_sgl;

    always_comb
    begin
        case (relop)
            REL_EQ:  rel_true = ($signed(dst_hi) == $signed(opnd_b));
            REL_LT:  rel_true = ($signed(dst_hi) <  $signed(opnd_b));
            REL_GT:  rel_true = ($signed(dst_hi) >  $signed(opnd_b));
            REL_NE:  rel_true = ($signed(dst_hi) != $signed(opnd_b));
            REL_LE:  rel_true = ($signed(dst_hi) <= $signed(opnd_b));
            REL_GE:  rel_true = ($signed(dst_hi) >= $signed(opnd_b));
            default: rel_true = 1'b0;
        endcase
    end

    always_comb
    begin
        case (op_code)
            single_to_double:   fp_res = fp_convert({32'h0, src_hi}, 1'b1);
            single_add:         fp_res = fp_add({32'h0, dst_hi}, {32'h0, src_hi}, 1'b0, 1'b0);
            single_subtract:    fp_res = fp_add({32'h0, dst_hi}, {32'h0, src_hi}, 1'b0, 1'b1);
            single_multiply:    fp_res = fp_mul({32'h0, dst_hi}, {32'h0, src_hi}, 1'b0);
            single_divide:      fp_res = fp_div({32'h0, dst_hi}, {32'h0, src_hi}, 1'b0);
            int_to_single:      fp_res = int_to_fp(src_hi, 1'b0);
            int_to_double:      fp_res = int_to_fp(src_hi, 1'b1);
            double_add_op:      fp_res = fp_add(dst_pair, src_pair, 1'b1, 1'b0);
            double_subtract_op: fp_res = fp_add(dst_pair, src_pair, 1'b1, 1'b1);
            double_multiply_op: fp_res = fp_mul(dst_pair, src_pair, 1'b1);
            double_divide_op:   fp_res = fp_div(dst_pair, src_pair, 1'b1);
            double_to_single:   fp_res = fp_convert(src_pair, 1'b0);
            default:            fp_res = 64'h0;
        endcase
    end

    always_comb
    begin
        nxt_res_hi  = res_hi_ff;
        nxt_res_lo  = res_lo_ff;
        nxt_pair_wr = pair_wr_ff;
        nxt_done    = op_valid;
        if (op_valid)
        begin
            nxt_pair_wr = 1'b0;
            nxt_res_lo  = RES_ZERO;
            case (op_code)
                real_round_to_int:   nxt_res_hi = fp_to_int({32'h0, src_hi}, 1'b0, 1'b1);
                real_trunc_to_int:   nxt_res_hi = fp_to_int({32'h0, src_hi}, 1'b0, 1'b0);
                int_to_single:       nxt_res_hi = fp_res[31:0];
                single_to_double:
                begin
                    {nxt_res_hi, nxt_res_lo} = fp_res;
                    nxt_pair_wr = 1'b1;
                end
                single_add, single_subtract, single_multiply, single_divide:
                    nxt_res_hi = fp_res[31:0];
                single_negate:       nxt_res_hi = {~src_hi[31], src_hi[30:0]};
                double_round_to_int: nxt_res_hi = fp_to_int(src_pair, 1'b1, 1'b1);
                double_trunc_to_int: nxt_res_hi = fp_to_int(src_pair, 1'b1, 1'b0);
                int_to_double, double_add_op, double_subtract_op, double_multiply_op,
                double_divide_op:
                begin
                    {nxt_res_hi, nxt_res_lo} = fp_res;
                    nxt_pair_wr = 1'b1;
                end
                double_negate_op:
                begin
                    {nxt_res_hi, nxt_res_lo} = {~src_hi[31], src_hi[30:0], src_lo};
                    nxt_pair_wr = 1'b1;
                end
                double_to_single:    nxt_res_hi = fp_res[31:0];
                bit_clear_op:
                begin
                    {nxt_res_hi, nxt_res_lo} = dst_pair & ~(64'h1 << bit_pos);
                    nxt_pair_wr = 1'b1;
                end
                bit_set_op:
                begin
                    {nxt_res_hi, nxt_res_lo} = dst_pair | (64'h1 << bit_pos);
                    nxt_pair_wr = 1'b1;
                end
                bit_test_op:         nxt_res_hi = {31'h0, dst_pair[bit_pos]};
                relation_test:       nxt_res_hi = {31'h0, rel_true};
                unsigned_compare:
                    nxt_res_hi = order_code(dst_hi < opnd_b, dst_hi == opnd_b);
                pair_signed_compare:
                    nxt_res_hi = order_code($signed(dst_pair) < $signed(src_pair),
                                            dst_pair == src_pair);
                single_compare:
                    nxt_res_hi = sm_compare({32'h0, dst_hi}, {32'h0, src_hi}, 1'b0);
                double_compare:      nxt_res_hi = sm_compare(dst_pair, src_pair, 1'b1);
                rotate_left:         nxt_res_hi = rot_wide[63:32];
                logical_left:        nxt_res_hi = dst_hi << cnt_sgl;
                logical_right:       nxt_res_hi = dst_hi >> cnt_sgl;
                arith_left:
                    nxt_res_hi = {dst_hi[31], 31'(dst_hi[30:0] << cnt_sgl)};
                arith_right:         nxt_res_hi = 32'($signed(dst_hi) >>> cnt_sgl);
                pair_logical_left:
                begin
                    {nxt_res_hi, nxt_res_lo} = dst_pair << cnt_pair;
                    nxt_pair_wr = 1'b1;
                end
                pair_logical_right:
                begin
                    {nxt_res_hi, nxt_res_lo} = dst_pair >> cnt_pair;
                    nxt_pair_wr = 1'b1;
                end
                default:             nxt_res_hi = dst_hi;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            done_ff    <= 1'b0;
            pair_wr_ff <= 1'b0;
            res_hi_ff  <= 32'h00000000;
            res_lo_ff  <= 32'h00000000;
        end
        else
        begin
            done_ff    <= nxt_done;
            pair_wr_ff <= nxt_pair_wr;
            res_hi_ff  <= nxt_res_hi;
            res_lo_ff  <= nxt_res_lo;
        end
    end

endmodule : real_bit_compare_shift_unit

// *** core/real_bit_compare_shift_unit_pkg.sv ***
package real_bit_compare_shift_unit_pkg;

    // real formats: sign, biased exponent, fraction
    localparam int          SGL_BIAS      = 127;
    localparam int          DBL_BIAS      = 1023;
    localparam int          SGL_EXP_MAX   = 255;
    localparam int          DBL_EXP_MAX   = 2047;
    localparam logic [7:0]  SGL_EXP_ONES  = 8'hff;
    localparam logic [10:0] DBL_EXP_ONES  = 11'h7ff;

    // integer results
    localparam logic [31:0] RES_MINUS_ONE = 32'hffffffff;
    localparam logic [31:0] RES_ZERO      = 32'h00000000;
    localparam logic [31:0] RES_PLUS_ONE  = 32'h00000001;
    localparam logic [31:0] INT_POS_SAT   = 32'h7fffffff;
    localparam logic [31:0] INT_NEG_SAT   = 32'h80000000;

    // relation select for the test operation
    localparam logic [2:0]  REL_EQ        = 3'h0;
    localparam logic [2:0]  REL_LT        = 3'h1;
    localparam logic [2:0]  REL_GT        = 3'h2;
    localparam logic [2:0]  REL_NE        = 3'h3;
    localparam logic [2:0]  REL_LE        = 3'h4;
    localparam logic [2:0]  REL_GE        = 3'h5;

    // field widths
    localparam int          IMM_W         = 4;
    localparam int          SGL_CNT_W     = 5;
    localparam int          PAIR_CNT_W    = 6;
    localparam logic [5:0]  PAIR_TOP_BIT  = 6'h3f;

    typedef enum logic [5:0] {
        real_round_to_int   = 6'h00,
        real_trunc_to_int   = 6'h01,
        int_to_single       = 6'h02,
        single_to_double    = 6'h03,
        single_add          = 6'h04,
        single_subtract     = 6'h05,
        single_multiply     = 6'h06,
        single_divide       = 6'h07,
        single_negate       = 6'h08,
        double_round_to_int = 6'h09,
        double_trunc_to_int = 6'h0a,
        int_to_double       = 6'h0b,
        double_add_op       = 6'h0c,
        double_subtract_op  = 6'h0d,
        double_multiply_op  = 6'h0e,
        double_divide_op    = 6'h0f,
        double_negate_op    = 6'h10,
        double_to_single    = 6'h11,
        bit_clear_op        = 6'h12,
        bit_set_op          = 6'h13,
        bit_test_op         = 6'h14,
        relation_test       = 6'h15,
        unsigned_compare    = 6'h16,
        pair_signed_compare = 6'h17,
        single_compare      = 6'h18,
        double_compare      = 6'h19,
        rotate_left         = 6'h1a,
        logical_left        = 6'h1b,
        logical_right       = 6'h1c,
        arith_left          = 6'h1d,
        arith_right         = 6'h1e,
        pair_logical_left   = 6'h1f,
        pair_logical_right  = 6'h20
    } op_e;

    typedef struct packed {
        logic               sgn;
        logic signed [13:0] exp;
        logic [63:0]        man;
        logic               zero;
    } fp_s;

endpackage : real_bit_compare_shift_unit_pkg

// *** test/real_bit_compare_shift_unit_asserts.sv ***
`timescale 1ns/1ns
module real_bit_compare_shift_unit_asserts
    import real_bit_compare_shift_unit_pkg::*;
(
    input wire logic        ref_clk,
    input wire logic        rst_n,
    input wire logic        op_valid,
    input wire op_e         op_code,
    input wire logic        imm_sel,
    input wire logic [2:0]  relop,
    input wire logic [3:0]  imm_val,
    input wire logic [31:0] dst_hi,
    input wire logic [31:0] dst_lo,
    input wire logic [31:0] src_hi,
    input wire logic [31:0] src_lo,
    input wire logic        done_ff,
    input wire logic        pair_wr_ff,
    input wire logic [31:0] res_hi_ff,
    input wire logic [31:0] res_lo_ff
);
    logic [63:0] dpair;
    logic [5:0]  bidx;
    logic [4:0]  scnt;
    assign dpair = {dst_hi, dst_lo};
    assign bidx  = src_hi[5:0];
    assign scnt  = src_hi[4:0];
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    done_latency_a: assert property (op_valid |=> done_ff)
        else $error("done missing after request");
    done_idle_a: assert property (!op_valid |=> !done_ff)
        else $error("done without request");
    result_hold_a: assert property (!op_valid |=> $stable(res_hi_ff) && $stable(res_lo_ff))
        else $error("result moved while idle");
    bit_clear_a: assert property (op_valid && op_code == bit_clear_op |=> pair_wr_ff &&
        {res_hi_ff, res_lo_ff} == ($past(dpair) & ~(64'h1 << (6'h3f - $past(bidx)))))
        else $error("bit clear wrong");
    bit_set_a: assert property (op_valid && op_code == bit_set_op |=> pair_wr_ff &&
        {res_hi_ff, res_lo_ff} == ($past(dpair) | (64'h1 << (6'h3f - $past(bidx)))))
        else $error("bit set wrong");
    bit_test_a: assert property (op_valid && op_code == bit_test_op |=>
        res_hi_ff == 32'(($past(dpair) >> (6'h3f - $past(bidx))) & 64'h1))
        else $error("bit test wrong");
    unsigned_cmp_a: assert property (op_valid && op_code == unsigned_compare && !imm_sel |=>
        res_hi_ff == ($past(dst_hi) < $past(src_hi) ? RES_MINUS_ONE :
        ($past(dst_hi) == $past(src_hi) ? RES_ZERO : RES_PLUS_ONE)))
        else $error("unsigned compare wrong");
    rotate_imm_a: assert property (op_valid && op_code == rotate_left && imm_sel |=>
        res_hi_ff == 32'(({$past(dst_hi), $past(dst_hi)} << $past(imm_val)) >> 32))
        else $error("rotate wrong");
    arith_right_a: assert property (op_valid && op_code == arith_right && !imm_sel |=>
        res_hi_ff == 32'($signed($past(dst_hi)) >>> $past(scnt)))
        else $error("arithmetic right wrong");
endmodule : real_bit_compare_shift_unit_asserts

// *** test/real_bit_compare_shift_unit_test.sv ***
`timescale 1ns/1ns
module real_bit_compare_shift_unit_test
    import real_bit_compare_shift_unit_pkg::*;
;
    typedef struct {op_e op; logic is; logic [3:0] iv; logic [31:0] dh, dl, sh, sl, eh, el;
        logic pw;} row_s;
    logic        ref_clk, rst_n, op_valid, imm_sel, done_ff, pair_wr_ff;
    op_e         op_code;
    logic [2:0]  relop;
    logic [3:0]  imm_val;
    logic [31:0] dst_hi, dst_lo, src_hi, src_lo, res_hi_ff, res_lo_ff, rx_ff, rx1_ff;
    int          errors, n_tests;
    row_s        rows[$];
    real_bit_compare_shift_unit uut (.ref_clk, .rst_n, .op_valid, .op_code, .imm_sel, .relop,
        .imm_val, .dst_hi, .dst_lo, .src_hi, .src_lo, .done_ff, .pair_wr_ff, .res_hi_ff, .res_lo_ff);
    reg_file_model rf (.ref_clk, .rst_n, .done_ff, .pair_wr_ff, .res_hi_ff, .res_lo_ff, .rx_ff,
        .rx1_ff);
    initial
    begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end
    initial
    begin
        #50000;
        errors++;
        results();
    end
    task results;
        $display("tests %0d errors %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : results
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            errors++;
            $display("BAD %0t saw %h want %h", $time, seen, exp);
        end
    endtask : chk
    task r(input op_e o, input logic i, input logic [3:0] v, input logic [31:0] dh, dl, sh, sl,
        eh, el, input logic p);
        rows.push_back('{o, i, v, dh, dl, sh, sl, eh, el, p});
    endtask : r
    task set(input row_s x);
        op_code = x.op;
        imm_sel = x.is;
        imm_val = x.iv;
        {dst_hi, dst_lo, src_hi, src_lo} = {x.dh, x.dl, x.sh, x.sl};
    endtask : set
    task go(input row_s x);
        @(negedge ref_clk);
        set(x);
        op_valid = 1'b1;
        @(negedge ref_clk);
        op_valid = 1'b0;
    endtask : go
    initial
    begin
        {rst_n, op_valid, imm_sel, relop, imm_val, dst_hi, dst_lo, src_hi, src_lo} = '0;
        op_code = single_add;
        r(single_subtract, 0, 0, 32'h40000000, 0, 32'h3f800000, 0, 32'h3f800000, 0, 0);
        r(single_divide, 0, 0, 32'h40c00000, 0, 32'h40000000, 0, 32'h40400000, 0, 0);
        r(single_negate, 0, 0, 0, 0, 32'h3f800000, 0, 32'hbf800000, 0, 0);
        r(real_round_to_int, 0, 0, 0, 0, 32'hc0200000, 0, 32'hfffffffd, 0, 0);
        r(real_trunc_to_int, 0, 0, 0, 0, 32'hc0300000, 0, 32'hfffffffe, 0, 0);
        r(int_to_single, 0, 0, 0, 0, 32'h01000001, 0, 32'h4b800001, 0, 0);
        r(single_to_double, 0, 0, 0, 0, 32'h3f800000, 0, 32'h3ff00000, 0, 1);
        r(double_subtract_op, 0, 0, 32'h40000000, 0, 32'h3ff00000, 0, 32'h3ff00000, 0, 1);
        r(double_to_single, 0, 0, 0, 0, 32'h3ff00000, 0, 32'h3f800000, 0, 0);
        r(bit_clear_op, 0, 0, '1, '1, 32'h20, 0, '1, 32'h7fffffff, 1);
        r(bit_set_op, 0, 0, 0, 0, 32'h7f, 0, 0, 1, 1);
        r(bit_test_op, 0, 0, 32'h80000000, 0, 32'h40, 0, 1, 0, 0);
        r(relation_test, 1, 7, 7, 0, 0, 0, 1, 0, 0);
        r(unsigned_compare, 0, 0, '1, 0, 1, 0, 1, 0, 0);
        r(pair_signed_compare, 0, 0, '1, 0, 0, 1, '1, 0, 0);
        r(single_compare, 0, 0, 32'hbf800000, 0, 32'h3f800000, 0, '1, 0, 0);
        r(double_compare, 0, 0, 32'h3ff00000, 0, 32'hbff00000, 0, 1, 0, 0);
        r(rotate_left, 1, 4, 32'h80000001, 0, 0, 0, 32'h18, 0, 0);
        r(logical_right, 1, 15, 32'h80000000, 0, 0, 0, 32'h00010000, 0, 0);
        r(arith_left, 1, 1, 32'h40000001, 0, 0, 0, 2, 0, 0);
        r(arith_right, 0, 0, 32'h80000000, 0, 32'h24, 0, 32'hf8000000, 0, 0);
        r(pair_logical_left, 0, 0, 0, 1, 32'h7f, 0, 32'h80000000, 0, 1);
        r(pair_logical_right, 1, 1, 1, 0, 0, 0, 0, 32'h80000000, 1);
        r(single_add, 0, 0, 32'h3f800000, 0, 32'h40000000, 0, 32'h40400000, 0, 0);
        r(single_multiply, 0, 0, 32'h40000000, 0, 32'h40400000, 0, 32'h40c00000, 0, 0);
        r(double_add_op, 0, 0, 32'h3ff00000, 0, 32'h3ff00000, 0, 32'h40000000, 0, 1);
        r(double_divide_op, 0, 0, 32'h40100000, 0, 32'h40000000, 0, 32'h40000000, 0, 1);
        r(double_negate_op, 0, 0, 0, 0, 32'h3ff00000, 1, 32'hbff00000, 1, 1);
        r(int_to_double, 0, 0, 0, 0, 3, 0, 32'h40080000, 0, 1);
        r(double_round_to_int, 0, 0, 0, 0, 32'h40040000, 0, 3, 0, 0);
        r(logical_left, 0, 0, 1, 0, 32'h3f, 0, 32'h80000000, 0, 0);
        r(single_divide, 0, 0, 32'h3f800000, 0, 0, 0, 32'h7f800000, 0, 0);
        repeat (12) @(posedge ref_clk);
        @(negedge ref_clk);
        chk(res_hi_ff, 0);
        chk(res_lo_ff | {30'h0, done_ff, pair_wr_ff}, 0);
        rst_n = 1'b1;
        foreach (rows[k])
        begin
            go(rows[k]);
            chk(32'(done_ff), 1);
            chk(res_hi_ff, rows[k].eh);
            chk(res_lo_ff, rows[k].el);
            chk(32'(pair_wr_ff), 32'(rows[k].pw));
            @(negedge ref_clk);
            chk(rx_ff, rows[k].eh);
            if (rows[k].pw)
                chk(rx1_ff, rows[k].el);
        end
        $display("row tests done");
        for (int k = 0; k < 8; k++)
        begin
            relop = 3'(k);
            go('{relation_test, 0, 0, '1, 0, 1, 0, 0, 0, 0});
            chk(res_hi_ff, 32'(6'h1a >> k)  & 32'h1);
        end
        $display("relation tests done");
        @(negedge ref_clk);
        set(rows[0]);
        op_valid = 1'b1;
        @(negedge ref_clk);
        chk(res_hi_ff, rows[0].eh);
        set(rows[17]);
        @(negedge ref_clk);
        op_valid = 1'b0;
        chk(res_hi_ff, rows[17].eh);
        repeat (3) @(negedge ref_clk);
        chk({res_hi_ff[30:0], done_ff}, {rows[17].eh[30:0], 1'b0});
        $display("back to back and hold done");
        rst_n = 1'b0;
        #1;
        chk(res_hi_ff, 0);
        chk(res_lo_ff | {30'h0, done_ff, pair_wr_ff}, 0);
        @(negedge ref_clk);
        rst_n = 1'b1;
        go(rows[20]);
        chk(res_hi_ff, rows[20].eh);
        $display("mid run reset done");
        results();
    end
endmodule : real_bit_compare_shift_unit_test
bind real_bit_compare_shift_unit real_bit_compare_shift_unit_asserts chk_u (.ref_clk(ref_clk),
    .rst_n(rst_n), .op_valid(op_valid), .op_code(op_code), .imm_sel(imm_sel), .relop(relop),
    .imm_val(imm_val), .dst_hi(dst_hi), .dst_lo(dst_lo), .src_hi(src_hi), .src_lo(src_lo),
    .done_ff(done_ff), .pair_wr_ff(pair_wr_ff), .res_hi_ff(res_hi_ff), .res_lo_ff(res_lo_ff));

// *** test/reg_file_model.sv ***
`timescale 1ns/1ns
module reg_file_model
(
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    input  wire logic        done_ff,
    input  wire logic        pair_wr_ff,
    input  wire logic [31:0] res_hi_ff,
    input  wire logic [31:0] res_lo_ff,
    output logic [31:0]      rx_ff,
    output logic [31:0]      rx1_ff
);
    // write back, second register only on a pair write
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rx_ff  <= 32'h0;
            rx1_ff <= 32'h0;
        end
        else if (done_ff)
        begin
            rx_ff <= res_hi_ff;
            if (pair_wr_ff)
                rx1_ff <= res_lo_ff;
        end
    end
endmodule : reg_file_model
